// [inc/spi_passthrough_pkg.sv]
package spi_passthrough_pkg;

   // Buffer geometry.
   localparam int BUF_WORDS = 8;
   localparam int WORD_BITS = 32;
   localparam int BUF_BITS  = BUF_WORDS * WORD_BITS;

   // Command codes accepted on the serial line.
   localparam logic [7:0] CMD_WR_BUF   = 8'h02;
   localparam logic [7:0] CMD_RD_BUF   = 8'h03;
   localparam logic [7:0] CMD_RD_STA_A = 8'h04;
   localparam logic [7:0] CMD_RD_STA_B = 8'h05;

   // Last bit index of a byte phase and of the data phase.
   localparam logic [7:0] BYTE_LAST = 8'h07;
   localparam logic [7:0] DATA_LAST = 8'hff;
   localparam logic [7:0] CNT_ONE   = 8'h01;

   // Status byte layout.
   localparam int ST_WR_BUSY  = 0;
   localparam int ST_RD_EMPTY = 1;
   localparam int ST_CNT_LO   = 2;
   localparam int ST_CNT_HI   = 4;
   localparam logic [2:0] COMM_STEP    = 3'h1;
   localparam logic [7:0] STATUS_RESET = 8'h02;

   // Protocol phases within one chip-select frame.
   typedef enum logic [2:0] {
      PH_CMD,
      PH_ADDR,
      PH_WDATA,
      PH_RDATA,
      PH_STAT,
      PH_IGNORE
   } phase_t;

   // Maps a data-phase bit number to {word, bit in word}.
   // Bytes go least significant first, bits within a byte most significant first.
   function automatic logic [7:0] buf_pos(input logic [7:0] n);
      buf_pos = {n[7:5], n[4:3], ~n[2:0]};
   endfunction : buf_pos

endpackage : spi_passthrough_pkg

// [design/pin_sync.sv]
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and control.
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Asynchronous inputs and their synchronised copies.
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Two flip-flops per line; the first is read only by the second.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else if (ce) begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;

endmodule : pin_sync

// [design/spi_slave_passthrough_link.sv]
// Notes on behaviour
// - Sample on rising clock, drive on falling.
// - Chip select high aborts, returns to idle.
// - Transaction opens with 8-bit command byte.
// - Command 02 fills eight receive words.
// - Command 03 sends eight transmit words.
// - Commands 04, 05 return the status byte.
// - Buffer data phase is exactly 256 bits.
// - Status read sends one byte after command.
// - Extra alert output beside four serial lines.
// - Status: write busy, read empty, count.
// - Alert rises on change, falls on read.
// - Buffer words travel least significant byte first.
module spi_slave_passthrough_link
   import spi_passthrough_pkg::*;
(
   // Clock, reset and clock enable.
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 ce,
   // Serial link to the master.
   input  wire logic                 sclk,
   input  wire logic                 cs_n,
   input  wire logic                 mosi,
   output      logic                 miso,
   output      logic                 status_alert_line,
   // Local transmit buffer loading.
   input  wire logic                 tx_load,
   input  wire logic [2:0]           tx_load_index,
   input  wire logic [WORD_BITS-1:0] tx_load_data,
   // Local status control.
   input  wire logic                 wr_release,
   input  wire logic                 rd_arm,
   // Local view of received data and status.
   output      logic [BUF_BITS-1:0]  rx_words,
   output      logic [7:0]           status_byte,
   output      logic                 wr_done,
   output      logic                 rd_done,
   output      logic                 sta_done
);

   logic [2:0]                          sync_q;
   logic                                sclk_s;
   logic                                cs_hi;
   logic                                mosi_s;
   logic                                sclk_q_ff;
   logic                                sclk_rise;
   logic                                sclk_fall;
   phase_t                              phase_ff;
   logic [7:0]                          cnt_ff;
   logic [6:0]                          cmd_sh_ff;
   logic [7:0]                          cmd_byte;
   logic [7:0]                          pos;
   logic [7:0]                          sta_sh_ff;
   logic [BUF_WORDS-1:0][WORD_BITS-1:0] rx_buf_ff;
   logic [BUF_WORDS-1:0][WORD_BITS-1:0] tx_buf_ff;
   logic                                miso_ff;
   logic [7:0]                          status_ff;
   logic [7:0]                          status_prev_ff;
   logic                                alert_ff;
   logic                                wr_done_ff;
   logic                                rd_done_ff;
   logic                                sta_done_ff;
   logic                                live_rise;
   logic                                ev_wr;
   logic                                ev_rd;
   logic                                ev_sta;
   logic                                st_changed;
   logic [2:0]                          comm_cnt;

   // Bring clock, select and data lines into this domain together.
   pin_sync #(.WIDTH(3)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .din   ({sclk, cs_n, mosi}),
      .dout  (sync_q)
   );

   assign sclk_s = sync_q[2];
   assign cs_hi  = sync_q[1];
   assign mosi_s = sync_q[0];

   // Edge finder on the synchronised serial clock.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclk_q_ff <= 1'b0;
      end else if (ce) begin
         sclk_q_ff <= sclk_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_q_ff;
   assign sclk_fall = ~sclk_s & sclk_q_ff;
   assign live_rise = ce & ~cs_hi & sclk_rise;
   assign cmd_byte  = {cmd_sh_ff, mosi_s};
   assign pos       = buf_pos(cnt_ff);

   // Completion events on the last sampled bit of each data phase.
   assign ev_wr  = live_rise && (phase_ff == PH_WDATA) && (cnt_ff == DATA_LAST);
   assign ev_rd  = live_rise && (phase_ff == PH_RDATA) && (cnt_ff == DATA_LAST);
   assign ev_sta = live_rise && (phase_ff == PH_STAT) && (cnt_ff == BYTE_LAST);

   // Protocol sequencer: command, then address and data, or status.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_ff  <= PH_CMD;
         cnt_ff    <= '0;
         cmd_sh_ff <= '0;
         sta_sh_ff <= '0;
      end else if (ce) begin
         if (cs_hi) begin
            phase_ff <= PH_CMD;
            cnt_ff   <= '0;
         end else if (sclk_rise) begin
            cnt_ff <= cnt_ff + CNT_ONE;
            case (phase_ff)
               PH_CMD: begin
                  cmd_sh_ff <= cmd_byte[6:0];
                  if (cnt_ff == BYTE_LAST) begin
                     cnt_ff    <= '0;
                     sta_sh_ff <= status_ff;
                     if (cmd_byte == CMD_WR_BUF || cmd_byte == CMD_RD_BUF) begin
                        phase_ff <= PH_ADDR;
                     end else if (cmd_byte == CMD_RD_STA_A || cmd_byte == CMD_RD_STA_B) begin
                        phase_ff <= PH_STAT;
                     end else begin
                        phase_ff <= PH_IGNORE;
                     end
                  end
               end
               PH_ADDR: begin
                  // The address byte is expected to be zero and is not used.
                  if (cnt_ff == BYTE_LAST) begin
                     cnt_ff   <= '0;
                     phase_ff <= (cmd_sh_ff[0]) ? PH_RDATA : PH_WDATA;
                  end
               end
               PH_WDATA, PH_RDATA: begin
                  if (cnt_ff == DATA_LAST) begin
                     phase_ff <= PH_IGNORE;
                  end
               end
               PH_STAT: begin
                  if (cnt_ff == BYTE_LAST) begin
                     phase_ff <= PH_IGNORE;
                  end
               end
               PH_IGNORE: begin
                  cnt_ff <= cnt_ff;
               end
               default: begin
                  phase_ff <= PH_CMD;
               end
            endcase
         end
      end
   end

   // Receive buffer written bit by bit during a write data phase.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_buf_ff <= '0;
      end else if (live_rise && phase_ff == PH_WDATA) begin
         rx_buf_ff[pos[7:5]][pos[4:0]] <= mosi_s;
      end
   end

   // Transmit buffer loaded by local logic.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_buf_ff <= '0;
      end else if (ce && tx_load) begin
         tx_buf_ff[tx_load_index] <= tx_load_data;
      end
   end

   // Outgoing bit changes on the falling serial clock edge.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         miso_ff <= 1'b0;
      end else if (ce) begin
         if (cs_hi) begin
            miso_ff <= 1'b0;
         end else if (sclk_fall) begin
            case (phase_ff)
               PH_RDATA: miso_ff <= tx_buf_ff[pos[7:5]][pos[4:0]];
               PH_STAT:  miso_ff <= sta_sh_ff[~cnt_ff[2:0]];
               default:  miso_ff <= 1'b0;
            endcase
         end
      end
   end

   assign comm_cnt   = status_ff[ST_CNT_HI:ST_CNT_LO];
   assign st_changed = (status_ff != status_prev_ff);

   // Status byte; a hardware set wins over a local clear.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_ff      <= STATUS_RESET;
         status_prev_ff <= STATUS_RESET;
      end else if (ce) begin
         status_prev_ff <= status_ff;
         if (ev_wr) begin
            status_ff[ST_WR_BUSY] <= 1'b1;
         end else if (wr_release) begin
            status_ff[ST_WR_BUSY] <= 1'b0;
         end
         if (ev_rd) begin
            status_ff[ST_RD_EMPTY] <= 1'b1;
         end else if (rd_arm) begin
            status_ff[ST_RD_EMPTY] <= 1'b0;
         end
         if (ev_wr || ev_rd) begin
            status_ff[ST_CNT_HI:ST_CNT_LO] <= comm_cnt + COMM_STEP;
         end
      end
   end

   // Alert line: raised on any status change, dropped by a status read.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alert_ff <= 1'b0;
      end else if (ce) begin
         if (st_changed) begin
            alert_ff <= 1'b1;
         end else if (ev_sta) begin
            alert_ff <= 1'b0;
         end
      end
   end

   // One-cycle done pulses to local logic.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_done_ff  <= 1'b0;
         rd_done_ff  <= 1'b0;
         sta_done_ff <= 1'b0;
      end else if (ce) begin
         wr_done_ff  <= ev_wr;
         rd_done_ff  <= ev_rd;
         sta_done_ff <= ev_sta;
      end
   end

   // Outputs, each taken from a flip-flop.
   assign miso              = miso_ff;
   assign status_alert_line = alert_ff;
   assign rx_words          = rx_buf_ff;
   assign status_byte       = status_ff;
   assign wr_done           = wr_done_ff;
   assign rd_done           = rd_done_ff;
   assign sta_done          = sta_done_ff;

   // Checks on the protocol engine.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n || !ce);

   sequence s_cmd_end;
      phase_ff == PH_CMD && live_rise && cnt_ff == BYTE_LAST;
   endsequence

   AST_CS_ABORT: assert property (cs_hi |=> phase_ff == PH_CMD && cnt_ff == '0)
      else $error("chip select high did not return the engine to idle");
   AST_MISO_EDGE: assert property ($changed(miso_ff) |-> $past(sclk_fall) || $past(cs_hi))
      else $error("outgoing bit changed away from a falling edge");
   AST_CMD_DECODE: assert property (s_cmd_end |=> phase_ff != PH_CMD && cnt_ff == '0)
      else $error("command byte did not end the command phase");
   AST_WR_DONE: assert property (wr_done_ff |-> $past(phase_ff) == PH_WDATA
                                 && $past(cnt_ff) == DATA_LAST)
      else $error("write done without 256 data bits");
   AST_RD_DONE: assert property (rd_done_ff |-> $past(phase_ff) == PH_RDATA
                                 && $past(cnt_ff) == DATA_LAST)
      else $error("read done without 256 data bits");
   AST_STA_DONE: assert property (sta_done_ff |-> $past(phase_ff) == PH_STAT
                                  && $past(cnt_ff) == BYTE_LAST)
      else $error("status done without one status byte");
   AST_CNT_ADV: assert property ((wr_done_ff || rd_done_ff)
                                 |-> comm_cnt == $past(comm_cnt) + COMM_STEP)
      else $error("transfer counter did not advance by one");
   AST_WR_BUSY: assert property (wr_done_ff |-> status_ff[ST_WR_BUSY])
      else $error("write busy not set after a buffer write");
   AST_ALERT_SET: assert property (st_changed |=> alert_ff)
      else $error("alert not raised on status change");
   AST_ALERT_CLR: assert property (sta_done_ff && !$past(st_changed) |-> !alert_ff)
      else $error("alert not lowered after a status read");
   AST_LSB_BYTE: assert property (live_rise && phase_ff == PH_WDATA && cnt_ff == '0
                                  |=> rx_buf_ff[0][BYTE_LAST[2:0]] == $past(mosi_s))
      else $error("first data bit did not land in bit 7 of word 0");

endmodule : spi_slave_passthrough_link

// [testbench/spi_master_model.sv]
module spi_master_model
   import spi_passthrough_pkg::*;
(
   // Bench clock.
   input  wire logic clk,
   // Serial link to the slave.
   input  wire logic miso,
   output      logic sclk,
   output      logic cs_n,
   output      logic mosi
);
   timeunit 1ns;
   timeprecision 1ps;

   // The link idles with the clock low and the slave deselected.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // Finds where serial data bit n sits among the eight buffer words.
   function automatic int pos(input int n);
      pos = 32 * (n / 32) + 8 * ((n % 32) / 8) + 7 - (n % 8);
   endfunction : pos

   // Runs one frame; a stop_at below the frame length raises chip select early.
   task automatic xfer(input logic [7:0] cmd, input logic [255:0] wd, input int stop_at,
                       output logic [255:0] rd, output logic [7:0] st);
      int   total;
      int   n;
      logic b;
      total = (cmd == CMD_WR_BUF || cmd == CMD_RD_BUF) ? 272 : 16;
      rd = '0;
      st = '0;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (8) @(posedge clk);
      for (int i = 0; i < total && i != stop_at; i++) begin
         n = i - 16;
         if (i < 8) b = cmd[7 - i];
         else if (i < 16 && total == 272) b = 1'b0;
         else if (cmd == CMD_WR_BUF) b = wd[pos(n)];
         else b = 1'($urandom);
         mosi <= b;
         repeat (8) @(posedge clk);
         sclk <= 1'b1;
         if (i >= 16 && total == 272) rd[pos(n)] = miso;
         else if (i >= 8 && total == 16) st[15 - i] = miso;
         repeat (8) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (8) @(posedge clk);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (16) @(posedge clk);
   endtask : xfer
endmodule : spi_master_model

// [testbench/spi_slave_passthrough_link_test.sv]
module spi_slave_passthrough_link_test
   import spi_passthrough_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk, rst_n, ce, sclk, cs_n, mosi, miso, status_alert_line;
   logic                 tx_load, wr_release, rd_arm, wr_done, rd_done, sta_done;
   logic                 busy_e, empty_e, alert_e;
   logic [2:0]           tx_load_index, cnt_e;
   logic [WORD_BITS-1:0] tx_load_data;
   logic [BUF_BITS-1:0]  rx_words, rx_e, tx_e, rd;
   logic [7:0]           status_byte, st;
   int                   err_count, checked, done_n;

   spi_slave_passthrough_link uut (.clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .miso(miso), .status_alert_line(status_alert_line),
      .tx_load(tx_load), .tx_load_index(tx_load_index), .tx_load_data(tx_load_data),
      .wr_release(wr_release), .rd_arm(rd_arm), .rx_words(rx_words),
      .status_byte(status_byte), .wr_done(wr_done), .rd_done(rd_done), .sta_done(sta_done));
   spi_master_model m (.clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Counts local completion pulses, weighted 1, 4 and 16 so that each kind is told apart.
   always @(posedge clk) begin
      done_n <= done_n + int'(wr_done === 1'b1) + 4 * int'(rd_done === 1'b1)
                + 16 * int'(sta_done === 1'b1);
   end

   task automatic check_bits(input logic [255:0] got, input logic [255:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check_bits

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check_byte

   // Expected status byte from the bench's own flags.
   function automatic logic [7:0] st_e();
      st_e = {3'h0, cnt_e, empty_e, busy_e};
   endfunction : st_e

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // Fills all eight transmit words back to back with random data.
   task automatic load_tx();
      logic [31:0] d;
      for (int k = 0; k < 8; k++) begin
         d = $urandom;
         tx_e[32*k +: 32] = d;
         @(posedge clk);
         tx_load <= 1'b1;
         tx_load_index <= 3'(k);
         tx_load_data <= d;
      end
      @(posedge clk);
      tx_load <= 1'b0;
   endtask : load_tx

   // Pulses the local clears; nothing is taken while ce is low.
   task automatic local_op(input logic rel, input logic arm);
      @(posedge clk);
      wr_release <= rel;
      rd_arm <= arm;
      @(posedge clk);
      wr_release <= 1'b0;
      rd_arm <= 1'b0;
      if (ce === 1'b1 && rel && busy_e) {busy_e, alert_e} = 2'h1;
      if (ce === 1'b1 && arm && empty_e) {empty_e, alert_e} = 2'h1;
      repeat (3) @(posedge clk);
      check_byte(status_byte, st_e());
      check_byte({7'h00, status_alert_line}, {7'h00, alert_e});
   endtask : local_op

   // One frame from the master, then checks of every local result.
   task automatic run(input logic [7:0] cmd, input int stop_at);
      logic [255:0] w;
      logic [7:0]   s0;
      logic         sta, full;
      logic [7:0]   d_e;
      int           n0;
      for (int k = 0; k < 8; k++) w[32*k +: 32] = $urandom;
      sta = (cmd == CMD_RD_STA_A || cmd == CMD_RD_STA_B);
      full = stop_at > 271 || (sta && stop_at > 15);
      s0 = st_e();
      n0 = done_n;
      d_e = 8'h00;
      m.xfer(cmd, w, stop_at, rd, st);
      // Data bits shifted in before an abort stay in the receive buffer.
      if (cmd == CMD_WR_BUF) begin
         for (int n = 0; n < stop_at - 16 && n < 256; n++) rx_e[m.pos(n)] = w[m.pos(n)];
      end
      if (full) begin
         case (cmd)
            CMD_WR_BUF: begin
               rx_e = w;
               busy_e = 1'b1;
               d_e = 8'h01;
            end
            CMD_RD_BUF: begin
               check_bits(rd, tx_e);
               empty_e = 1'b1;
               d_e = 8'h04;
            end
            CMD_RD_STA_A, CMD_RD_STA_B: begin
               check_byte(st, s0);
               d_e = 8'h10;
            end
            default: check_byte(st, 8'h00);
         endcase
         if (cmd == CMD_WR_BUF || cmd == CMD_RD_BUF) {cnt_e, alert_e} = {cnt_e + 3'h1, 1'b1};
         if (sta) alert_e = 1'b0;
      end
      check_bits(rx_words, rx_e);
      check_byte(status_byte, st_e());
      check_byte(8'(done_n - n0), d_e);
      check_byte({7'h00, status_alert_line}, {7'h00, alert_e});
      check_byte({7'h00, miso}, 8'h00);
      $display("test cmd %h stop %0d done", cmd, stop_at);
   endtask : run

   // Cuts a hung run short.
   initial begin
      #800_000;
      err_count++;
      report_and_stop();
   end

   // Main sequence.
   initial begin
      void'($urandom(51113));
      {rst_n, tx_load, wr_release, rd_arm, tx_load_index, tx_load_data} = '0;
      ce = 1'b1;
      {busy_e, empty_e, alert_e, cnt_e, rx_e, tx_e} = {3'h2, 3'h0, 512'h0};
      {err_count, checked} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check_byte(status_byte, STATUS_RESET);
      load_tx();
      local_op(1'b0, 1'b1);
      run(CMD_RD_STA_A, 999);
      run(CMD_RD_BUF, 999);
      run(CMD_RD_STA_B, 999);
      run(CMD_WR_BUF, 150);
      run(CMD_RD_STA_A, 12);
      run(8'h07, 999);
      ce <= 1'b0;
      local_op(1'b0, 1'b1);
      ce <= 1'b1;
      for (int k = 0; k < 9; k++) begin
         run(CMD_WR_BUF, 999);
         local_op(k[0], 1'b0);
      end
      run(CMD_RD_STA_B, 999);
      report_and_stop();
   end
endmodule : spi_slave_passthrough_link_test
